/* hw/radio_power_mode_control.sv */
// operating-mode state machine of the radio with its serial register port
`timescale 1ns/1ps
`default_nettype none
module radio_power_mode_control #(
	parameter int POR_CYCLES = radio_mode_pkg::POR_CYC,
	parameter int IDLE_CYCLES = radio_mode_pkg::IDLE_RESP_CYC,
	parameter int ACT_CYCLES = radio_mode_pkg::ACT_RESP_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic shutdown_pin,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic ext_event,
	input wire logic lowbat_event,
	input wire logic [15:0] wake_interval,
	input wire logic lfosc_opt_en,
	input wire logic aux_opt_en,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	output logic radio_irq_n,
	output radio_mode_pkg::state_e mode,
	output logic main_regulator_on,
	output logic low_power_regulator_on,
	output logic spi_on,
	output logic lfosc_on,
	output logic aux_on,
	output logic temp_sensor_on,
	output logic lowbat_on,
	output logic xtal_on,
	output logic pll_on,
	output logic pa_on,
	output logic rx_on,
	output logic tx_rx_ready
);
	localparam int W = radio_mode_pkg::CNT_W;
	function automatic radio_mode_pkg::state_e decode_mode(input logic [7:0] m);
		if (m[radio_mode_pkg::TXON_BIT])
			return radio_mode_pkg::ST_TX;
		if (m[radio_mode_pkg::RXON_BIT])
			return radio_mode_pkg::ST_RX;
		if (m[radio_mode_pkg::PLLON_BIT])
			return radio_mode_pkg::ST_TUNE;
		if (m[radio_mode_pkg::XTON_BIT])
			return radio_mode_pkg::ST_READY;
		if (m[radio_mode_pkg::ENLBD_BIT] || m[radio_mode_pkg::TSEN_BIT])
			return radio_mode_pkg::ST_SENSOR;
		if (m[radio_mode_pkg::ENWT_BIT])
			return radio_mode_pkg::ST_SLEEP;
		return radio_mode_pkg::ST_STANDBY;
	endfunction
	// pin synchronisers; stage 2 only serves edge detection
	logic [2:0] shd_q, sck_q, cs_q;
	logic [1:0] mosi_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shd_q <= 3'h7;
			sck_q <= 3'h0;
			cs_q <= 3'h7;
			mosi_q <= 2'h0;
		end else if (clk_en) begin
			shd_q <= {shd_q[1:0], shutdown_pin};
			sck_q <= {sck_q[1:0], spi_sck};
			cs_q <= {cs_q[1:0], spi_cs_n};
			mosi_q <= {mosi_q[0], spi_mosi};
		end
	end
	logic shd, shd_fall, sck_rise, sck_fall, cs_act, mosi;
	assign shd = shd_q[1];
	assign shd_fall = shd_q[2] & ~shd_q[1];
	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign sck_fall = sck_q[2] & ~sck_q[1];
	assign cs_act = ~cs_q[1];
	assign mosi = mosi_q[1];
	radio_mode_pkg::state_e state_q, state_d;
	logic [7:0] mode_reg_q, mode_reg_d, istat1_q, istat1_d, istat2_q, istat2_d;
	logic [W-1:0] cnt_q, cnt_d;
	logic [15:0] wake_q, wake_d;
	logic port_live;
	assign port_live = state_q != radio_mode_pkg::ST_SHUTDOWN
		&& state_q != radio_mode_pkg::ST_POR;
	// serial register port
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, rd_q, rd_d, wdata;
	logic [6:0] addr_q, addr_d;
	logic wr_q, wr_d, miso_q, miso_d, drive_q, drive_d;
	logic wr_commit, rd_done;
	always_comb begin
		bit_d = bit_q;
		sh_d = sh_q;
		rd_d = rd_q;
		addr_d = addr_q;
		wr_d = wr_q;
		miso_d = miso_q;
		drive_d = drive_q;
		wr_commit = 1'b0;
		rd_done = 1'b0;
		wdata = {sh_q[6:0], mosi};
		if (!cs_act || !port_live) begin
			bit_d = 4'h0; // frame dropped when select rises early
			drive_d = 1'b0;
		end else begin
			drive_d = 1'b1;
			if (sck_rise) begin
				sh_d = wdata;
				bit_d = bit_q + 4'h1;
				if (bit_q == radio_mode_pkg::LAST_ADDR_BIT) begin
					wr_d = sh_q[6];
					addr_d = wdata[6:0];
					case (wdata[6:0])
					radio_mode_pkg::ADDR_ISTAT1: rd_d = istat1_q;
					radio_mode_pkg::ADDR_ISTAT2: rd_d = istat2_q;
					radio_mode_pkg::ADDR_MODE: rd_d = mode_reg_q;
					default: rd_d = 8'h00;
					endcase
				end
				if (bit_q == radio_mode_pkg::LAST_DATA_BIT) begin
					wr_commit = wr_q;
					rd_done = ~wr_q;
				end
			end
			if (sck_fall && bit_q[3]) begin
				miso_d = rd_q[7];
				rd_d = {rd_q[6:0], 1'b0};
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rd_q <= 8'h00;
			addr_q <= 7'h00;
			wr_q <= 1'b0;
			miso_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (clk_en) begin
			bit_q <= bit_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			miso_q <= miso_d;
			drive_q <= drive_d;
		end
	end
	// mode state machine, status flags and wake timer
	logic [7:0] set1, set2, clr1, clr2;
	radio_mode_pkg::state_e tgt;
	logic from_low;
	always_comb begin
		state_d = state_q;
		mode_reg_d = mode_reg_q;
		cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - W'(1);
		wake_d = 16'h0000;
		set1 = 8'h00;
		set2 = 8'h00;
		set1[radio_mode_pkg::IEXT_BIT] = ext_event;
		set2[radio_mode_pkg::ILBD_BIT] = lowbat_event & lowbat_on;
		if (lfosc_on) begin
			wake_d = wake_q + 16'h0001;
			if (wake_q >= wake_interval) begin
				wake_d = 16'h0000;
				set2[radio_mode_pkg::IWUT_BIT] = 1'b1;
			end
		end
		clr1 = {8{rd_done && addr_q == radio_mode_pkg::ADDR_ISTAT1}};
		clr2 = {8{rd_done && addr_q == radio_mode_pkg::ADDR_ISTAT2}};
		tgt = decode_mode(wdata);
		from_low = state_q == radio_mode_pkg::ST_STANDBY
			|| state_q == radio_mode_pkg::ST_SLEEP
			|| state_q == radio_mode_pkg::ST_SENSOR;
		case (state_q)
		radio_mode_pkg::ST_SHUTDOWN: begin
			if (shd_fall) begin
				state_d = radio_mode_pkg::ST_POR;
				cnt_d = W'(POR_CYCLES);
			end
		end
		radio_mode_pkg::ST_POR: begin
			if (cnt_q == '0) begin
				state_d = radio_mode_pkg::ST_READY;
				mode_reg_d = radio_mode_pkg::MODE_RESET;
				set2[radio_mode_pkg::IPOR_BIT] = 1'b1;
				set2[radio_mode_pkg::ICHIPRDY_BIT] = 1'b1;
			end
		end
		default: begin
			if (wr_commit && addr_q == radio_mode_pkg::ADDR_MODE) begin
				if (wdata[radio_mode_pkg::SWRST_BIT]) begin
					state_d = radio_mode_pkg::ST_READY;
					mode_reg_d = radio_mode_pkg::MODE_RESET;
				end else begin
					state_d = tgt;
					mode_reg_d = wdata;
					if ((tgt == radio_mode_pkg::ST_TX
						|| tgt == radio_mode_pkg::ST_RX) && tgt != state_q)
						cnt_d = from_low ? W'(IDLE_CYCLES) : W'(ACT_CYCLES);
				end
			end
		end
		endcase
		istat1_d = (istat1_q & ~clr1) | set1; // set beats clear
		istat2_d = (istat2_q & ~clr2) | set2;
		if (shd) begin
			state_d = radio_mode_pkg::ST_SHUTDOWN;
			mode_reg_d = 8'h00;
			istat1_d = radio_mode_pkg::ISTAT_RESET;
			istat2_d = radio_mode_pkg::ISTAT_RESET;
			cnt_d = '0;
			wake_d = 16'h0000;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= radio_mode_pkg::ST_SHUTDOWN;
			mode_reg_q <= 8'h00;
			istat1_q <= radio_mode_pkg::ISTAT_RESET;
			istat2_q <= radio_mode_pkg::ISTAT_RESET;
			cnt_q <= '0;
			wake_q <= 16'h0000;
		end else if (clk_en) begin
			state_q <= state_d;
			mode_reg_q <= mode_reg_d;
			istat1_q <= istat1_d;
			istat2_q <= istat2_d;
			cnt_q <= cnt_d;
			wake_q <= wake_d;
		end
	end
	// block enables follow the state, the mode register bits, the option inputs and pending interrupts
	logic irq_pend, low_mode, xtal_mode, act;
	assign irq_pend = |{istat1_q, istat2_q};
	assign low_mode = state_q == radio_mode_pkg::ST_STANDBY
		|| state_q == radio_mode_pkg::ST_SLEEP;
	assign xtal_mode = state_q == radio_mode_pkg::ST_READY
		|| state_q == radio_mode_pkg::ST_TUNE || pll_on;
	assign act = state_q == radio_mode_pkg::ST_TX
		|| state_q == radio_mode_pkg::ST_RX;
	assign mode = state_q;
	assign radio_irq_n = ~irq_pend;
	assign spi_on = port_live;
	assign low_power_regulator_on = low_mode & ~irq_pend;
	assign main_regulator_on = port_live & ~low_power_regulator_on;
	assign lfosc_on = state_q == radio_mode_pkg::ST_SLEEP
		|| state_q == radio_mode_pkg::ST_SENSOR
		|| (xtal_mode && (lfosc_opt_en
		|| mode_reg_q[radio_mode_pkg::ENWT_BIT]));
	assign aux_on = state_q == radio_mode_pkg::ST_SENSOR
		|| ((xtal_mode || state_q == radio_mode_pkg::ST_SLEEP)
		&& aux_opt_en);
	assign lowbat_on = aux_on & mode_reg_q[radio_mode_pkg::ENLBD_BIT];
	assign temp_sensor_on = aux_on & mode_reg_q[radio_mode_pkg::TSEN_BIT];
	assign xtal_on = xtal_mode;
	assign pll_on = state_q == radio_mode_pkg::ST_TUNE || act;
	assign pa_on = state_q == radio_mode_pkg::ST_TX;
	assign rx_on = state_q == radio_mode_pkg::ST_RX;
	assign tx_rx_ready = act && cnt_q == '0;
	assign spi_miso = miso_q;
	assign spi_miso_oe_n = ~drive_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	shdn_enter_a: assert property (clk_en && shd |=>
		state_q == radio_mode_pkg::ST_SHUTDOWN)
		else $error("shutdown pin high did not force shutdown");
	shdn_deaf_a: assert property (
		state_q == radio_mode_pkg::ST_SHUTDOWN |-> spi_miso_oe_n
		&& !spi_on && istat2_q == radio_mode_pkg::ISTAT_RESET)
		else $error("port or flags alive in shutdown");
	por_ready_a: assert property (clk_en && !shd
		&& state_q == radio_mode_pkg::ST_POR && cnt_q == '0 |=>
		state_q == radio_mode_pkg::ST_READY
		&& mode_reg_q == radio_mode_pkg::MODE_RESET)
		else $error("power-on reset did not end in ready");
	mode_write_a: assert property (clk_en && !shd && wr_commit
		&& port_live && addr_q == radio_mode_pkg::ADDR_MODE
		&& !wdata[radio_mode_pkg::SWRST_BIT] |=>
		state_q == decode_mode($past(wdata)))
		else $error("mode write not applied");
	standby_a: assert property (clk_en && !shd && wr_commit
		&& port_live && addr_q == radio_mode_pkg::ADDR_MODE
		&& wdata == radio_mode_pkg::MODE_STANDBY |=>
		state_q == radio_mode_pkg::ST_STANDBY)
		else $error("zero write did not give standby");
	sleep_a: assert property (clk_en && !shd && wr_commit
		&& port_live && addr_q == radio_mode_pkg::ADDR_MODE
		&& wdata == radio_mode_pkg::MODE_SLEEP |=>
		state_q == radio_mode_pkg::ST_SLEEP && lfosc_on)
		else $error("0x40 write did not give sleep");
	partial_a: assert property (clk_en && !shd && !wr_commit
		&& port_live |=> state_q == $past(state_q))
		else $error("mode moved without a complete write");
	regulator_a: assert property (low_power_regulator_on |->
		low_mode && !main_regulator_on)
		else $error("low-power regulator outside standby or sleep");
	stack_a: assert property ((pa_on || rx_on) |-> pll_on
		&& xtal_on && main_regulator_on && !(pa_on && rx_on))
		else $error("block enables not cumulative");
	irq_hold_a: assert property (clk_en && !shd && !radio_irq_n
		&& !rd_done |=> !radio_irq_n)
		else $error("interrupt line released without a read");
	ready_wait_a: assert property (clk_en && !shd && act
		&& !$past(act) && $past(from_low) |-> !tx_rx_ready)
		else $error("tx/rx ready too early");
	por_cov: cover property (state_q == radio_mode_pkg::ST_POR
		##1 state_q == radio_mode_pkg::ST_READY);
	tx_cov: cover property (tx_rx_ready && pa_on);
	sleep_cov: cover property (state_q == radio_mode_pkg::ST_SLEEP
		&& set2[radio_mode_pkg::IWUT_BIT]);
	irq_clr_cov: cover property (rd_done && !radio_irq_n);
endmodule
`default_nettype wire

/* include/radio_mode_pkg.sv */
// constants and types for the radio operating-mode controller
package radio_mode_pkg;
	// register addresses on the serial port
	localparam logic [6:0] ADDR_ISTAT1 = 7'h03;
	localparam logic [6:0] ADDR_ISTAT2 = 7'h04;
	localparam logic [6:0] ADDR_MODE = 7'h07;
	// mode control register fields
	localparam int XTON_BIT = 0;
	localparam int PLLON_BIT = 1;
	localparam int RXON_BIT = 2;
	localparam int TXON_BIT = 3;
	localparam int TSEN_BIT = 4;
	localparam int ENLBD_BIT = 5;
	localparam int ENWT_BIT = 6;
	localparam int SWRST_BIT = 7;
	localparam logic [7:0] MODE_RESET = 8'h01;
	localparam logic [7:0] MODE_STANDBY = 8'h00;
	localparam logic [7:0] MODE_SLEEP = 8'h40;
	// interrupt status fields
	localparam int IEXT_BIT = 3;
	localparam int IPOR_BIT = 0;
	localparam int ICHIPRDY_BIT = 1;
	localparam int ILBD_BIT = 2;
	localparam int IWUT_BIT = 3;
	localparam logic [7:0] ISTAT_RESET = 8'h00;
	// serial frame: one address byte then one data byte
	localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
	localparam logic [3:0] LAST_DATA_BIT = 4'hF;
	// response times
	localparam int CLK_PERIOD_NS = 10;
	localparam int SHDN_RESP_NS = 16800000;
	localparam int IDLE_RESP_NS = 800000;
	localparam int ACT_RESP_NS = 200000;
	localparam int SHDN_RESP_CYC = SHDN_RESP_NS / CLK_PERIOD_NS;
	localparam int IDLE_RESP_CYC = IDLE_RESP_NS / CLK_PERIOD_NS;
	localparam int ACT_RESP_CYC = ACT_RESP_NS / CLK_PERIOD_NS;
	localparam int POR_CYC = SHDN_RESP_CYC - ACT_RESP_CYC;
	localparam int CNT_W = 21;
	typedef enum logic [3:0] {
		ST_SHUTDOWN,
		ST_POR,
		ST_STANDBY,
		ST_SLEEP,
		ST_SENSOR,
		ST_READY,
		ST_TUNE,
		ST_TX,
		ST_RX
	} state_e;
endpackage

/* sim/radio_host_model.sv */
// host model: serial master and shutdown driver facing the radio
`timescale 1ns/1ps
`default_nettype none
module radio_host_model (
	output logic shutdown_pin,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n
);
	logic oe_seen_n;
	initial begin
		shutdown_pin = 1'b1;
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
		oe_seen_n = 1'b1;
	end
	// pin stays low except while shutdown is wanted
	task automatic pin(input logic v);
		shutdown_pin = v;
	endtask
	// nb below 16 cuts the frame; sck rests low between frames
	task automatic frame(input logic w, input logic [6:0] a,
		input logic [7:0] d, input int nb, output logic [7:0] q);
		logic [15:0] sh;
		sh = {w, a, d};
		q = 8'h00;
		// step off the system clock edges
		#1;
		spi_cs_n = 1'b0;
		#62.5;
		for (int i = 0; i < nb; i++) begin
			spi_mosi = sh[15 - i];
			#62.5;
			spi_sck = 1'b1;
			oe_seen_n = spi_miso_oe_n;
			if (i > 7)
				q = {q[6:0], spi_miso};
			#62.5;
			spi_sck = 1'b0;
		end
		#62.5;
		spi_cs_n = 1'b1;
		// released data line shows the inverse, not the last bit
		spi_mosi = ~spi_mosi;
	endtask
endmodule
`default_nettype wire

/* sim/radio_power_mode_control_tb.sv */
// self-checking bench for the radio operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module radio_power_mode_control_tb;
	localparam int POR_N = 50;
	localparam int IDLE_N = 40;
	localparam int ACT_N = 10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic ext_event = 1'b0;
	logic lowbat_event = 1'b0;
	logic lfosc_opt_en = 1'b0;
	logic aux_opt_en = 1'b0;
	logic [15:0] wake_interval = 16'hFFFF;
	wire shutdown_pin, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
	wire radio_irq_n, main_regulator_on, low_power_regulator_on, spi_on;
	wire lfosc_on, aux_on, temp_sensor_on, lowbat_on, xtal_on, pll_on;
	wire pa_on, rx_on, tx_rx_ready;
	radio_mode_pkg::state_e mode;
	wire [10:0] pw = {spi_on, lfosc_on, aux_on, temp_sensor_on, lowbat_on,
		xtal_on, pll_on, pa_on, rx_on, main_regulator_on, low_power_regulator_on};
	int error_cnt = 0;
	int n_compared = 0;
	logic [7:0] rd;
	always #5 clk = ~clk;
	radio_power_mode_control #(.POR_CYCLES(POR_N), .IDLE_CYCLES(IDLE_N),
		.ACT_CYCLES(ACT_N)) u_dut (.clk, .rst_n, .clk_en, .shutdown_pin,
		.spi_sck, .spi_cs_n, .spi_mosi, .ext_event, .lowbat_event,
		.wake_interval, .lfosc_opt_en, .aux_opt_en, .spi_miso, .spi_miso_oe_n,
		.radio_irq_n, .mode, .main_regulator_on, .low_power_regulator_on,
		.spi_on, .lfosc_on, .aux_on, .temp_sensor_on, .lowbat_on, .xtal_on,
		.pll_on, .pa_on, .rx_on, .tx_rx_ready);
	radio_host_model u_host (.shutdown_pin, .spi_sck, .spi_cs_n, .spi_mosi,
		.spi_miso, .spi_miso_oe_n);
	task automatic summarize();
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e,
		input string m);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s: %h vs %h", $time, m, s, e);
		end
	endtask
	task automatic wait_for(input radio_mode_pkg::state_e m, output int n);
		n = 0;
		while (mode !== m) begin
			@(negedge clk);
			n++;
			if (n > 600) begin
				check(0, 1, "wait");
				summarize();
			end
		end
	endtask
	task automatic wm(input logic [7:0] d);
		u_host.frame(1'b1, radio_mode_pkg::ADDR_MODE, d, 16, rd);
		repeat (8) @(negedge clk);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e,
		input string m);
		u_host.frame(1'b0, a, 8'h00, 16, rd);
		repeat (8) @(negedge clk);
		check(rd, e, m);
	endtask
	task automatic resp(input logic [7:0] d, input radio_mode_pkg::state_e s,
		input int lim);
		int n;
		int k;
		fork
			u_host.frame(1'b1, radio_mode_pkg::ADDR_MODE, d, 16, rd);
		join_none
		wait_for(s, n);
		k = 0;
		while (tx_rx_ready !== 1'b1 && k < lim + 9) begin
			@(negedge clk);
			k++;
		end
		check(k >= lim - 2 && k <= lim + 2, 1, "response");
		if (tx_rx_ready !== 1'b1)
			summarize();
		check(pw, s == radio_mode_pkg::ST_TX ? 11'h43A : 11'h436, "act");
		repeat (20) @(negedge clk);
	endtask
	task automatic t_por();
		int n;
		check(mode, radio_mode_pkg::ST_SHUTDOWN, "shutdown");
		check(pw, 11'h000, "off");
		@(negedge clk);
		u_host.pin(1'b0);
		wait_for(radio_mode_pkg::ST_READY, n);
		check(n >= POR_N && n <= POR_N + 6, 1, "por time");
		check(pw, 11'h422, "ready");
		check(radio_irq_n, 0, "por irq");
		rd_chk(radio_mode_pkg::ADDR_ISTAT2, 8'h03, "por stat");
		check(u_host.oe_seen_n, 0, "oe");
		check(radio_irq_n, 1, "irq off");
	endtask
	task automatic t_wake();
		int k;
		wake_interval = 16'h0013;
		wm(8'h40);
		k = 0;
		while (radio_irq_n !== 1'b0 && k < 60) begin
			@(negedge clk);
			k++;
		end
		check(k < 60, 1, "wake");
		if (k >= 60)
			summarize();
		check(mode, radio_mode_pkg::ST_SLEEP, "stay");
		check(low_power_regulator_on, 0, "pend");
		rd_chk(radio_mode_pkg::ADDR_ISTAT2, 8'h08, "wut");
		wm(8'h00);
		rd_chk(radio_mode_pkg::ADDR_ISTAT2, 8'h08, "wut2");
		check(low_power_regulator_on, 1, "lp");
		wake_interval = 16'hFFFF;
	endtask
	task automatic t_modes();
		logic [7:0] mv [6] = '{8'h00, 8'h40, 8'h60, 8'h50, 8'h01, 8'h02};
		logic [10:0] bv [6] = '{11'h401, 11'h601, 11'h742, 11'h782, 11'h422,
			11'h432};
		radio_mode_pkg::state_e sv [6] = '{radio_mode_pkg::ST_STANDBY,
			radio_mode_pkg::ST_SLEEP, radio_mode_pkg::ST_SENSOR,
			radio_mode_pkg::ST_SENSOR, radio_mode_pkg::ST_READY,
			radio_mode_pkg::ST_TUNE};
		for (int i = 0; i < 6; i++) begin
			wm(mv[i]);
			check(mode, sv[i], "mode");
			check(pw, bv[i], "blocks");
			rd_chk(radio_mode_pkg::ADDR_MODE, mv[i], "rdback");
		end
	endtask
	task automatic t_resp();
		wm(8'h00);
		resp(8'h08, radio_mode_pkg::ST_TX, IDLE_N);
		resp(8'h04, radio_mode_pkg::ST_RX, ACT_N);
		resp(8'h0C, radio_mode_pkg::ST_TX, ACT_N);
		wm(8'h40);
		resp(8'h04, radio_mode_pkg::ST_RX, IDLE_N);
		wm(8'h02);
		resp(8'h08, radio_mode_pkg::ST_TX, ACT_N);
	endtask
	task automatic t_misc();
		wm(8'h01);
		// frozen clock enable: an event must not reach the status flags
		clk_en = 1'b0;
		ext_event = 1'b1;
		repeat (4) @(negedge clk);
		clk_en = 1'b1;
		ext_event = 1'b0;
		repeat (2) @(negedge clk);
		check(radio_irq_n, 1, "frozen");
		check(mode, radio_mode_pkg::ST_READY, "frozen mode");
		u_host.frame(1'b1, radio_mode_pkg::ADDR_MODE, 8'h00, 12, rd);
		repeat (20) @(negedge clk);
		check(mode, radio_mode_pkg::ST_READY, "cut");
		u_host.frame(1'b1, 7'h05, 8'h40, 16, rd);
		repeat (8) @(negedge clk);
		check(mode, radio_mode_pkg::ST_READY, "addr");
		rd_chk(7'h05, 8'h00, "unmapped");
		lfosc_opt_en = 1'b1;
		aux_opt_en = 1'b1;
		repeat (4) @(negedge clk);
		check(pw, 11'h722, "opt");
		check(mode, radio_mode_pkg::ST_READY, "opt mode");
		lfosc_opt_en = 1'b0;
		aux_opt_en = 1'b0;
		ext_event = 1'b1;
		@(negedge clk);
		ext_event = 1'b0;
		repeat (30) @(negedge clk);
		check(radio_irq_n, 0, "held");
		rd_chk(radio_mode_pkg::ADDR_ISTAT1, 8'h08, "ext");
		check(radio_irq_n, 1, "free");
		wm(8'h60);
		lowbat_event = 1'b1;
		@(negedge clk);
		lowbat_event = 1'b0;
		rd_chk(radio_mode_pkg::ADDR_ISTAT2, 8'h04, "lowbat");
		wm(8'h02);
		wm(8'h80);
		check(mode, radio_mode_pkg::ST_READY, "swrst");
		rd_chk(radio_mode_pkg::ADDR_MODE, 8'h01, "swrst reg");
	endtask
	task automatic t_shdn();
		int n;
		u_host.pin(1'b1);
		repeat (5) @(negedge clk);
		check(mode, radio_mode_pkg::ST_SHUTDOWN, "pin");
		check(pw, 11'h000, "off");
		u_host.frame(1'b1, radio_mode_pkg::ADDR_MODE, 8'h08, 16, rd);
		@(negedge clk);
		check(u_host.oe_seen_n, 1, "deaf");
		check(mode, radio_mode_pkg::ST_SHUTDOWN, "no sel");
		u_host.pin(1'b0);
		wait_for(radio_mode_pkg::ST_READY, n);
		rd_chk(radio_mode_pkg::ADDR_MODE, 8'h01, "lost");
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_por();
		t_wake();
		t_modes();
		t_resp();
		t_misc();
		t_shdn();
		summarize();
	end
endmodule
`default_nettype wire
